// file: common/poc_pkg.sv
/*
  Shared constants and types of the PLL and oscillator control model.
  Assumes a single 100 MHz system clock; all cycle counts derive from it.
*/
package poc_pkg;

  // System clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLK_MHZ       = 1000 / CLK_PERIOD_NS;

  // Lock settling time (least, rounds up) and reference loss window (longest, rounds down)
  localparam int LOCK_TIME_NS = 500;
  localparam int REF_LOSS_NS  = 200;
  localparam logic [7:0] LOCK_CYCLES =
    8'((LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] REF_LOSS_CYCLES = 8'(REF_LOSS_NS / CLK_PERIOD_NS);

  // Oscillator nominal frequencies, indexed by the select field
  localparam int OSC_MHZ_SEL0 = 10;
  localparam int OSC_MHZ_SEL1 = 20;
  localparam int OSC_MHZ_SEL2 = 40;
  localparam int OSC_MHZ_SEL3 = 80;

  // Half period in system clocks, never below one
  function automatic logic [3:0] osc_half(input int mhz);
    int h;
    h = CLK_MHZ / (2 * mhz);
    return (h < 1) ? 4'h1 : 4'(h);
  endfunction

  localparam logic [3:0] OSC_HALF_SEL0 = osc_half(OSC_MHZ_SEL0);
  localparam logic [3:0] OSC_HALF_SEL1 = osc_half(OSC_MHZ_SEL1);
  localparam logic [3:0] OSC_HALF_SEL2 = osc_half(OSC_MHZ_SEL2);
  localparam logic [3:0] OSC_HALF_SEL3 = osc_half(OSC_MHZ_SEL3);

  // Loop product ceiling
  localparam logic [23:0] LOOP_PRODUCT_MAX = 24'h0000FF;

  // Register byte offsets
  localparam logic [4:0] CTRL_OFS       = 5'h00;
  localparam logic [4:0] DIVS_OFS       = 5'h04;
  localparam logic [4:0] OUTDIV_LO_OFS  = 5'h08;
  localparam logic [4:0] OUTDIV_HI_OFS  = 5'h0C;
  localparam logic [4:0] PHASE_OFS      = 5'h10;
  localparam logic [4:0] STATUS_OFS     = 5'h14;
  localparam logic [4:0] RATIO_OFS      = 5'h18;
  localparam logic [4:0] PHASE_STAT_OFS = 5'h1C;

  // Reset values and writable bits
  localparam logic [31:0] CTRL_RESET      = 32'h00000080;
  localparam logic [31:0] CTRL_WMASK      = 32'h000000FF;
  localparam logic [31:0] DIVS_RESET      = 32'h01010101;
  localparam logic [31:0] OUTDIV_LO_RESET = 32'h01010101;
  localparam logic [31:0] OUTDIV_HI_RESET = 32'h00000001;
  localparam logic [31:0] OUTDIV_HI_WMASK = 32'h000000FF;
  localparam logic [31:0] PHASE_RESET     = 32'h00000000;
  localparam logic [31:0] PHASE_WMASK     = 32'h000001FF;
  localparam logic [31:0] ALL_WMASK       = 32'hFFFFFFFF;

  typedef struct packed {
    logic [23:0] rsvd;
    logic        leaf_invert;
    logic        core_fb_mode;
    logic        pll_reset_n;
    logic [1:0]  ref_clk_select;
    logic [1:0]  osc_freq_sel;
    logic        osc_enable;
  } poc_ctrl_type;

  typedef struct packed {
    logic [7:0] feedback_output_divider;
    logic [7:0] post_div;
    logic [7:0] fb_mult;
    logic [7:0] pre_div;
  } poc_divs_type;

  typedef struct packed {
    logic [22:0] rsvd;
    logic        phase_apply_enable;
    logic [4:0]  out_select;
    logic [2:0]  value;
  } poc_phase_type;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] divs;
    logic [31:0] outdiv_lo;
    logic [31:0] outdiv_hi;
    logic [31:0] phase;
  } poc_regs_type;

  typedef struct packed {
    logic         waitreq;
    logic [31:0]  rdata;
    poc_regs_type regs;
    logic         ref_prev;
    logic [7:0]   ref_idle;
    logic         fb_prev;
    logic [7:0]   fb_idle;
    logic [7:0]   lock_cnt;
    logic         locked;
  } poc_top_state_type;

endpackage

// file: hdl/poc_osc.sv
/*
  Low-power oscillator model: a toggle divider off the system clock.
  Assumes a synchronous active-low reset copy from the top.
*/
`timescale 1ns/1ns
module poc_osc #(
  parameter int CNT_W = 4
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       enable,
  input  wire logic [1:0] freq_sel,
  output logic            clk_out
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             level;
  } poc_osc_state_type;

  poc_osc_state_type st;
  poc_osc_state_type next_st;
  logic [CNT_W-1:0]  half;

  if (CNT_W < 4) begin : g_chk
    $error("poc_osc: CNT_W must be at least 4");
  end

  // Half period for the chosen nominal rate
  // rate select
  always_comb begin
    unique case (freq_sel)
      2'h0: half = CNT_W'(poc_pkg::OSC_HALF_SEL0);
      2'h1: half = CNT_W'(poc_pkg::OSC_HALF_SEL1);
      2'h2: half = CNT_W'(poc_pkg::OSC_HALF_SEL2);
      2'h3: half = CNT_W'(poc_pkg::OSC_HALF_SEL3);
    endcase
  end

  // Toggle divider, stopped and low while disabled
  // clock gating
  always_comb begin
    next_st = st;
    if (!enable) begin
      next_st.cnt   = '0;
      next_st.level = 1'b0;
    end else if (st.cnt >= half - 1'b1) begin
      next_st.cnt   = '0;
      next_st.level = ~st.level;
    end else begin
      next_st.cnt = st.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign clk_out = st.level;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_osc_stopped: assert property (!enable |=> !st.level)
    else $error("oscillator runs while disabled");
  a_osc_half_rate: assert property (
    enable && $past(enable) && $past(freq_sel) == $past(freq_sel, 2) && $changed(st.level)
      |-> $past(st.cnt) == $past(half) - 1'b1)
    else $error("oscillator toggled off its half period");

endmodule

// file: hdl/poc_out_div.sv
/*
  One PLL output: divider by C with dynamic phase delay in half steps.
  Assumes one system clock equals half a post-divided PLL cycle.
*/
`timescale 1ns/1ns
module poc_out_div #(
  parameter int DIV_W = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             run,
  input  wire logic [DIV_W-1:0] divide,
  input  wire logic             invert,
  input  wire logic             apply,
  input  wire logic [2:0]       phase_value,
  output logic                  clk_out,
  output logic [2:0]            phase_now
);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             level;
    logic             out;
    logic [2:0]       phase;
    logic [2:0]       stall;
  } poc_div_state_type;

  poc_div_state_type st;
  poc_div_state_type next_st;
  logic [DIV_W-1:0]  div_eff;
  logic [2:0]        diff;

  if (DIV_W < 2) begin : g_chk
    $error("poc_out_div: DIV_W must be at least 2");
  end

  // Zero divide acts as one; phase step count wraps in three bits
  assign div_eff = (divide == '0) ? DIV_W'(1) : divide;
  assign diff    = phase_value - st.phase;

  // Divider with stall for phase delay
  always_comb begin
    next_st = st;
    if (!run) begin
      next_st.cnt   = '0;
      next_st.level = 1'b0;
      next_st.stall = 3'h0;
      if (apply) begin
        next_st.phase = phase_value;
      end
    end else if (st.stall != 3'h0) begin
      next_st.stall = st.stall - 3'h1;
    end else if (apply && diff != 3'h0) begin
      next_st.phase = phase_value;
      next_st.stall = diff - 3'h1;
    end else if (st.cnt >= div_eff - 1'b1) begin
      next_st.cnt   = '0;
      next_st.level = ~st.level;
    end else begin
      next_st.cnt = st.cnt + 1'b1;
    end
    next_st.out = next_st.level ^ invert;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign clk_out   = st.out;
  assign phase_now = st.phase;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_phase_update: assert property (
    run && st.stall == 3'h0 && apply |=> st.phase == $past(phase_value))
    else $error("phase not taken while apply high");
  a_phase_delay: assert property (
    run && st.stall == 3'h0 && apply && diff != 3'h0
      |=> st.stall == $past(diff) - 3'h1 && st.level == $past(st.level))
    else $error("phase delay steps wrong");

endmodule

// file: hdl/poc_top.sv
/*
  PLL and low-power oscillator control model with an Avalon-MM register
  slave: reference select, lock tracking, five divided outputs with
  dynamic phase shift. Assumes reference and feedback inputs are
  sampled on clk and that one clk is half a post-divided PLL cycle.
*/
`timescale 1ns/1ns
// Behaviour
// - Oscillator gives a core clock at 10, 20, 40 or 80 MHz nominal; the model toggles at 10, 25, 50 and 50 MHz.
// - Oscillator can be enabled or disabled to save power.
// - PLL takes four references and uses the one the two-bit select names.
// - Low PLL reset resets the PLL; high lets it run.
// - Output frequency is reference times M times feedback divider over N times C.
// - Lock indicator rises on lock and falls on detected loss of lock.
// - Phase value delays the output half a PLL cycle per step, up to 3.5.
// - Five-bit select picks which outputs take the phase shift.
// - While shift enable is high, selected outputs take the current phase value.
// - Four outputs feed global clocks; the fifth only regional clocks.
// - Outputs align on the falling edge; leaf polarity inverted by default.
module poc_top (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [3:0]  ref_clk_in,
  input  wire logic        core_feedback_in,
  output logic             osc_clk_out,
  output logic             pll_locked,
  output logic             pll_out_a,
  output logic             pll_out_b,
  output logic             pll_out_c,
  output logic             pll_out_d,
  output logic             pll_out_e
);

  poc_pkg::poc_top_state_type st;
  poc_pkg::poc_top_state_type next_st;

  logic [1:0]              rst_sync;
  logic                    rst_n;
  poc_pkg::poc_ctrl_type   ctrl;
  poc_pkg::poc_ctrl_type   ctrl_wr;
  poc_pkg::poc_divs_type   divs;
  poc_pkg::poc_phase_type  phase;
  logic [4:0][7:0]         out_div;
  logic [4:0]              outs;
  logic [4:0][2:0]         cur_phase;
  logic                    req;
  logic                    wr_now;
  logic                    ref_now;
  logic                    ref_edge;
  logic                    ref_active;
  logic                    fb_edge;
  logic                    fb_active;
  logic                    sel_change;
  logic                    run_ok;
  logic [23:0]             loop_product;
  logic                    cfg_ok;
  logic [15:0]             ratio_num;
  logic [15:0]             ratio_den;
  logic                    out_a_ok;
  logic [31:0]             status;
  logic [31:0]             rd_mux;

  // Reset release through two flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // Register views
  assign ctrl    = poc_pkg::poc_ctrl_type'(st.regs.ctrl);
  assign divs    = poc_pkg::poc_divs_type'(st.regs.divs);
  assign phase   = poc_pkg::poc_phase_type'(st.regs.phase);
  assign out_div = {st.regs.outdiv_hi[7:0], st.regs.outdiv_lo};

  // Byte-lane merge of a write into a register
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be,
                                        input logic [31:0] wmask);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
    return (old & ~m) | (wd & m);
  endfunction

  // Bus request and the write that completes this cycle
  assign req     = avs_read | avs_write;
  assign wr_now  = avs_write && !st.waitreq;
  assign ctrl_wr = poc_pkg::poc_ctrl_type'(merge(st.regs.ctrl, avs_writedata,
                                                 avs_byteenable, poc_pkg::CTRL_WMASK));

  // Configuration checks and frequency ratio
  // loop product check
  assign loop_product = divs.fb_mult * divs.post_div * divs.feedback_output_divider;
  assign cfg_ok       = loop_product <= poc_pkg::LOOP_PRODUCT_MAX;
  assign ratio_num    = divs.fb_mult * divs.feedback_output_divider;
  assign ratio_den    = divs.pre_div * out_div[0];
  assign out_a_ok     = {2'h0, ratio_num} <= {ratio_den, 2'h0};

  // Reference and feedback activity
  // reference select
  assign ref_now    = ref_clk_in[ctrl.ref_clk_select];
  assign ref_edge   = ref_now != st.ref_prev;
  assign ref_active = st.ref_idle < poc_pkg::REF_LOSS_CYCLES;
  assign fb_edge    = core_feedback_in != st.fb_prev;
  assign fb_active  = !ctrl.core_fb_mode || (st.fb_idle < poc_pkg::REF_LOSS_CYCLES);

  // Reference swap while running breaks lock
  // select under reset
  assign sel_change = wr_now && avs_address == poc_pkg::CTRL_OFS && ctrl.pll_reset_n
                      && ctrl_wr.ref_clk_select != ctrl.ref_clk_select;

  // Conditions for the loop to acquire and hold lock
  // reset level
  assign run_ok = ctrl.pll_reset_n && cfg_ok && ref_active && fb_active && !sel_change;

  // Status word
  assign status = {27'h0, ref_active, out_a_ok, cfg_ok, ctrl.osc_enable, st.locked};

  // Read data selection
  always_comb begin
    case (avs_address)
      poc_pkg::CTRL_OFS:       rd_mux = st.regs.ctrl;
      poc_pkg::DIVS_OFS:       rd_mux = st.regs.divs;
      poc_pkg::OUTDIV_LO_OFS:  rd_mux = st.regs.outdiv_lo;
      poc_pkg::OUTDIV_HI_OFS:  rd_mux = st.regs.outdiv_hi;
      poc_pkg::PHASE_OFS:      rd_mux = st.regs.phase;
      poc_pkg::STATUS_OFS:     rd_mux = status;
      poc_pkg::RATIO_OFS:      rd_mux = {ratio_den, ratio_num};
      poc_pkg::PHASE_STAT_OFS: rd_mux = {17'h0, cur_phase};
      default:                 rd_mux = 32'h0;
    endcase
  end

  // Next state: bus slave, activity monitors, lock tracking
  always_comb begin
    next_st = st;
    // One wait cycle, then the answer
    if (req && st.waitreq) begin
      next_st.waitreq = 1'b0;
      next_st.rdata   = rd_mux;
    end else begin
      next_st.waitreq = 1'b1;
    end
    // Writes land on the completing edge
    if (wr_now) begin
      case (avs_address)
        poc_pkg::CTRL_OFS:      next_st.regs.ctrl = 32'(ctrl_wr);
        poc_pkg::DIVS_OFS:      next_st.regs.divs = merge(st.regs.divs, avs_writedata,
                                  avs_byteenable, poc_pkg::ALL_WMASK);
        poc_pkg::OUTDIV_LO_OFS: next_st.regs.outdiv_lo = merge(st.regs.outdiv_lo,
                                  avs_writedata, avs_byteenable, poc_pkg::ALL_WMASK);
        poc_pkg::OUTDIV_HI_OFS: next_st.regs.outdiv_hi = merge(st.regs.outdiv_hi,
                                  avs_writedata, avs_byteenable, poc_pkg::OUTDIV_HI_WMASK);
        poc_pkg::PHASE_OFS:     next_st.regs.phase = merge(st.regs.phase, avs_writedata,
                                  avs_byteenable, poc_pkg::PHASE_WMASK);
        default:                next_st.regs = st.regs;
      endcase
    end
    // Reference edge watch, saturating idle count
    next_st.ref_prev = ref_now;
    if (ref_edge) begin
      next_st.ref_idle = 8'h00;
    end else if (st.ref_idle != 8'hFF) begin
      next_st.ref_idle = st.ref_idle + 8'h01;
    end
    next_st.fb_prev = core_feedback_in;
    if (fb_edge) begin
      next_st.fb_idle = 8'h00;
    end else if (st.fb_idle != 8'hFF) begin
      next_st.fb_idle = st.fb_idle + 8'h01;
    end
    if (!run_ok) begin
      next_st.lock_cnt = 8'h00;
      next_st.locked   = 1'b0;
    end else if (st.lock_cnt != poc_pkg::LOCK_CYCLES) begin
      next_st.lock_cnt = st.lock_cnt + 8'h01;
    end else begin
      next_st.locked = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st                <= '0;
      st.waitreq        <= 1'b1;
      st.regs.ctrl      <= poc_pkg::CTRL_RESET;
      st.regs.divs      <= poc_pkg::DIVS_RESET;
      st.regs.outdiv_lo <= poc_pkg::OUTDIV_LO_RESET;
      st.regs.outdiv_hi <= poc_pkg::OUTDIV_HI_RESET;
      st.regs.phase     <= poc_pkg::PHASE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Oscillator
  poc_osc #(.CNT_W(4)) u_osc (
    .clk      (clk),
    .rst_n    (rst_n),
    .enable   (ctrl.osc_enable),
    .freq_sel (ctrl.osc_freq_sel),
    .clk_out  (osc_clk_out)
  );

  // Five outputs restart together at lock, so outputs with the same C value align
  for (genvar i = 0; i < 5; i++) begin : g_out
    poc_out_div #(.DIV_W(8)) u_div (
      .clk         (clk),
      .rst_n       (rst_n),
      .run         (st.locked),
      .divide      (out_div[i]),
      .invert      (ctrl.leaf_invert),
      .apply       (phase.phase_apply_enable & phase.out_select[i]),
      .phase_value (phase.value),
      .clk_out     (outs[i]),
      .phase_now   (cur_phase[i])
    );
  end

  // outputs a to d global, e regional only
  assign pll_out_a       = outs[0];
  assign pll_out_b       = outs[1];
  assign pll_out_c       = outs[2];
  assign pll_out_d       = outs[3];
  assign pll_out_e       = outs[4];
  assign pll_locked      = st.locked;
  assign avs_readdata    = st.rdata;
  assign avs_waitrequest = st.waitreq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_bus_answer: assert property (
    req && st.waitreq |=> !st.waitreq ##1 st.waitreq)
    else $error("bus answer not one cycle after request");
  a_lock_reset: assert property (!ctrl.pll_reset_n |=> !st.locked)
    else $error("lock high while PLL held in reset");
  a_reset_clears: assert property (
    $fell(ctrl.pll_reset_n) |=> st.lock_cnt == 8'h00 ##1 !st.locked)
    else $error("PLL reset did not clear lock tracking");
  a_lock_rise: assert property (
    $rose(st.locked) |-> $past(st.lock_cnt) == poc_pkg::LOCK_CYCLES && $past(run_ok))
    else $error("lock rose before settling count");
  a_lock_loss: assert property (st.locked && !ref_active |=> !st.locked)
    else $error("lock kept after reference loss");
  a_ref_select: assert property (
    st.ref_prev != ref_clk_in[ctrl.ref_clk_select] |=> st.ref_idle == 8'h00)
    else $error("selected reference edge not seen");
  a_select_swap: assert property (sel_change |=> !st.locked && st.lock_cnt == 8'h00)
    else $error("reference swap while running kept lock");

endmodule

// file: tb/poc_fabric_model.sv
/*
  Fabric-side partner: four reference clocks and a core feedback clock.
  Assumes the bench clock drives it; a reference whose run bit is low
  stands still at low level.
*/
`timescale 1ns/1ns
module poc_fabric_model (
  input  wire logic       clk,
  input  wire logic [3:0] run,
  output logic      [3:0] ref_clk_in,
  output logic            core_feedback_in
);
  logic [2:0] cnt = 3'h0;

  // single PLL only
  // Reference clocks, an edge every one or two cycles when running
  always_ff @(posedge clk) begin
    cnt <= cnt + 3'h1;
    for (int i = 0; i < 4; i++) begin
      ref_clk_in[i] <= run[i] & (cnt[2] ^ cnt[0]);
    end
  end

  // feedback routed back
  // Feedback clock returned to the core input
  always_ff @(posedge clk) begin
    core_feedback_in <= cnt[1];
  end
endmodule

// file: tb/test_poc_top.sv
/*
  Self-checking bench of the PLL and oscillator control top.
  Assumes the Avalon-MM slave answers by waitrequest; reads are queued.
*/
`timescale 1ns/1ns
module test_poc_top;
  logic        clk, nrst, avs_read, avs_write, avs_waitrequest, core_feedback_in;
  logic        osc_clk_out, pll_locked, pa, pb, pc, pd, pe, probe_sel;
  logic [4:0]  avs_address;
  logic [31:0] wd, avs_readdata;
  logic [3:0]  be, ref_clk_in, ref_run;
  logic [31:0] expq[$];
  logic [14:0] phase_exp;
  logic [2:0]  v;
  int          fail_count = 0;
  int          checked = 0;
  int          h;
  int          halves[4] = '{5, 2, 1, 1};
  wire         probe = probe_sel ? pa : osc_clk_out;

  poc_top dut (.clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(wd), .avs_byteenable(be),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ref_clk_in(ref_clk_in), .core_feedback_in(core_feedback_in),
    .osc_clk_out(osc_clk_out), .pll_locked(pll_locked), .pll_out_a(pa),
    .pll_out_b(pb), .pll_out_c(pc), .pll_out_d(pd), .pll_out_e(pe));
  poc_fabric_model model (.clk(clk), .run(ref_run), .ref_clk_in(ref_clk_in),
    .core_feedback_in(core_feedback_in));

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task report_and_stop;
    if (fail_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task give_up;
    fail_count++;
    $display("BAD %0t wait ran out", $time);
    report_and_stop;
  endtask

  task check_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task check_count(input int got, input int exp);
    checked++;
    if (got != exp) begin
      fail_count++;
      $display("BAD %0t count %0d expected %0d", $time, got, exp);
    end
  endtask

  // One bus cycle; a read queues its expected word
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    if (!wr) expq.push_back(d);
    @(posedge clk);
    avs_address <= a;
    wd <= d;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) give_up;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task wait_lock(input logic want);
    int n;
    for (n = 0; n < 200 && pll_locked !== want; n++) @(posedge clk);
    if (n >= 200) give_up;
  endtask

  // Cycles between two changes of the probed clock
  task measure(output int hp);
    logic last;
    int   n;
    @(posedge clk);
    last = probe;
    for (n = 0; n < 30 && probe === last; n++) @(posedge clk);
    last = probe;
    hp = 0;
    while (hp < 30 && probe === last) begin
      @(posedge clk);
      hp++;
    end
  endtask

  // Read monitor takes the oldest expectation
  always @(posedge clk) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      if (expq.size() == 0) give_up;
      else check_word(avs_readdata, expq.pop_front());
    end
  end

  // Overall limit
  initial begin
    repeat (20000) @(posedge clk);
    give_up;
  end

  // Main sequence
  initial begin
    nrst = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    wd = 32'h0;
    be = 4'hF;
    ref_run = 4'h3;
    probe_sel = 1'b0;
    void'($urandom(32'he4029f63));
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    bus(0, poc_pkg::CTRL_OFS, poc_pkg::CTRL_RESET);
    bus(0, poc_pkg::DIVS_OFS, poc_pkg::DIVS_RESET);
    bus(0, poc_pkg::OUTDIV_LO_OFS, poc_pkg::OUTDIV_LO_RESET);
    bus(0, poc_pkg::OUTDIV_HI_OFS, poc_pkg::OUTDIV_HI_RESET);
    bus(0, poc_pkg::PHASE_OFS, poc_pkg::PHASE_RESET);
    bus(0, 5'h02, 32'h0);
    check_word({31'h0, pll_locked}, 32'h0);
    check_word({27'h0, pa, pb, pc, pd, pe}, 32'h1F);
    for (int s = 0; s < 4; s++) begin
      bus(1, poc_pkg::CTRL_OFS, 32'h81 | (s << 1));
      measure(h);
      check_count(h, halves[s]);
    end
    bus(1, poc_pkg::CTRL_OFS, 32'h80);
    repeat (3) @(posedge clk);
    check_word({31'h0, osc_clk_out}, 32'h0);
    bus(1, poc_pkg::DIVS_OFS, 32'h01110F01);
    bus(0, poc_pkg::STATUS_OFS, 32'h14);
    bus(0, poc_pkg::RATIO_OFS, 32'h0001000F);
    bus(1, poc_pkg::DIVS_OFS, 32'h01101001);
    bus(0, poc_pkg::STATUS_OFS, 32'h10);
    bus(1, poc_pkg::DIVS_OFS, poc_pkg::DIVS_RESET);
    bus(1, poc_pkg::CTRL_OFS, 32'hA0);
    wait_lock(1'b1);
    check_word({27'h0, pa, pb, pc, pd, pe}, {27'h0, {5{pa}}});
    // first output within four times reference
    bus(0, poc_pkg::STATUS_OFS, 32'h1D);
    bus(1, poc_pkg::OUTDIV_LO_OFS, 32'h01010103);
    probe_sel = 1'b1;
    measure(h);
    check_count(h, 3);
    ref_run <= 4'h2;
    wait_lock(1'b0);
    // reset held far beyond 10 ns
    bus(1, poc_pkg::CTRL_OFS, 32'h80);
    bus(1, poc_pkg::CTRL_OFS, 32'h88);
    check_word({31'h0, pll_locked}, 32'h0);
    bus(1, poc_pkg::CTRL_OFS, 32'hA8);
    wait_lock(1'b1);
    // Shifts while running, so outputs stall; slowest output period is 6 clk
    phase_exp = 15'h0;
    for (int n = 0; n < 5; n++) begin
      v = 3'($urandom_range(7, 1));
      bus(1, poc_pkg::PHASE_OFS, {29'h0, v});
      repeat (6) @(posedge clk);
      bus(1, poc_pkg::PHASE_OFS, {23'h0, 1'b1, 5'(1 << n), v});
      // hold and gap, four periods of the slowest output
      repeat (24) @(posedge clk);
      bus(1, poc_pkg::PHASE_OFS, {29'h0, v});
      repeat (24) @(posedge clk);
      phase_exp[3*n +: 3] = v;
      bus(0, poc_pkg::PHASE_STAT_OFS, {17'h0, phase_exp});
    end
    // Select swap while running drops lock; core feedback mode then relocks
    ref_run <= 4'h3;
    bus(1, poc_pkg::CTRL_OFS, 32'hE0);
    @(posedge clk);
    check_word({31'h0, pll_locked}, 32'h0);
    wait_lock(1'b1);
    bus(1, poc_pkg::CTRL_OFS, 32'h80);
    wait_lock(1'b0);
    bus(1, poc_pkg::PHASE_OFS, 32'hFFFFFFFF);
    bus(0, poc_pkg::PHASE_OFS, 32'h1FF);
    bus(0, poc_pkg::PHASE_STAT_OFS, 32'h7FFF);
    repeat (3) @(posedge clk);
    check_count(expq.size(), 0);
    report_and_stop;
  end
endmodule
